/* File: tsr_regs.sv */
`timescale 1ns/10ps
// Register bank of the temperature sensor, reached by byte operations
module tsr_regs
  import tsr_pkg::*;
#(
  parameter logic [7:0] P_ID_CODE = 8'h5A  // Identification byte, value arbitrary
) (
  input  wire logic        i_clk,             // Core clock, 25 MHz
  input  wire logic        i_rstn,            // Core reset, sync, active low
  input  wire logic        i_lk_clk,          // Link clock
  input  wire logic        i_lk_rstn,         // Link reset, sync, active low
  input  wire logic        i_lk_req,          // Link operation request
  input  wire tsr_op_t     i_lk_op,           // Start, write, read or stop
  input  wire logic [7:0]  i_lk_wdata,        // Byte written by the host
  output logic             o_lk_busy,         // Operation in flight
  output logic             o_lk_done,         // Operation finished pulse
  output logic [7:0]       o_lk_rdata,        // Byte read by the host
  input  wire logic        i_conv_valid,      // New conversion result pulse
  input  wire logic [15:0] i_conv_data,       // 16-bit conversion result
  input  wire logic        i_below_low,       // Temperature under low_limit
  input  wire logic        i_above_high,      // Temperature over high_limit
  input  wire logic        i_above_crit,      // Temperature over critical_limit
  input  wire logic        i_low_recovered,   // Above low_limit plus margin
  input  wire logic        i_high_recovered,  // Below high_limit minus margin
  input  wire logic        i_crit_recovered,  // Below critical_limit minus margin
  output logic [7:0]       o_cfg,             // Configuration register
  output logic             o_res16,           // 16-bit resolution selected
  output tsr_mode_t        o_mode,            // Operating mode
  output logic [7:0]       o_status,          // Status register value
  output logic [7:0]       o_ptr              // Register pointer
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tsr_xfer_if xf ();

  logic [7:0]  ptr_r;
  logic [7:0]  cfg_r;
  logic [15:0] temp_r;
  logic [7:0]  rdata_r;
  logic        fl_low_r;
  logic        fl_high_r;
  logic        fl_crit_r;
  logic        rdy_n_r;
  logic        ack_r;
  tsr_phase_t  phase_r;
  logic [7:0]  status_byte;
  logic [7:0]  rd_mux;
  logic        rd_req;
  logic        wr_req;
  logic        ptr_wr;
  logic        reg_wr;
  logic        cfg_wr;
  logic        temp_rd;
  logic        st_rd;
  tsr_mode_t   wr_mode;

  // ----------------------------------------------------------------
  // Link crossing
  // ----------------------------------------------------------------
  tsr_link_cdc u_cdc (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_lk_clk   (i_lk_clk),
    .i_lk_rstn  (i_lk_rstn),
    .i_lk_req   (i_lk_req),
    .i_lk_op    (i_lk_op),
    .i_lk_wdata (i_lk_wdata),
    .o_lk_busy  (o_lk_busy),
    .o_lk_done  (o_lk_done),
    .o_lk_rdata (o_lk_rdata),
    .xf         (xf.link)
  );

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // The first byte written after a start, before any read, lands in the pointer
  assign rd_req  = xf.req && (xf.op == TSR_OP_READ);
  assign wr_req  = xf.req && (xf.op == TSR_OP_WRITE);
  assign ptr_wr  = wr_req && (phase_r != TSR_PH_DATA);
  assign reg_wr  = wr_req && (phase_r == TSR_PH_DATA);
  assign cfg_wr  = reg_wr && (ptr_r == TSR_ADR_CONFIG);
  assign temp_rd = rd_req && ((ptr_r == TSR_ADR_TEMP_HI) || (ptr_r == TSR_ADR_TEMP_LO));
  assign st_rd   = rd_req && (ptr_r == TSR_ADR_STATUS);
  assign wr_mode = tsr_mode_t'(xf.wdata[TSR_CFG_MODE_LO +: 2]);

  // Transaction phase
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      phase_r <= TSR_PH_IDLE;
    end else if (xf.req) begin
      case (xf.op)
        TSR_OP_START: phase_r <= TSR_PH_POINTER;
        TSR_OP_STOP:  phase_r <= TSR_PH_IDLE;
        TSR_OP_WRITE: phase_r <= TSR_PH_DATA;
        TSR_OP_READ:  phase_r <= TSR_PH_DATA;
        default:      phase_r <= TSR_PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------
  // Only the temperature high byte advances, so a two-byte read of the
  // value needs a single pointer write
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ptr_r <= TSR_PTR_RST;
    end else if (ptr_wr) begin
      ptr_r <= xf.wdata;
    end else if (rd_req && (ptr_r == TSR_ADR_TEMP_HI)) begin
      ptr_r <= TSR_ADR_TEMP_LO;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_r <= TSR_CFG_RST;
    end else if (cfg_wr) begin
      cfg_r <= xf.wdata;
    end
  end

  assign o_cfg   = cfg_r;
  assign o_res16 = cfg_r[TSR_CFG_RES];
  assign o_mode  = tsr_mode_t'(cfg_r[TSR_CFG_MODE_LO +: 2]);

  // ----------------------------------------------------------------
  // Temperature value
  // ----------------------------------------------------------------
  // In 13-bit mode alarm bits are taken with the result so they match the value read
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      temp_r <= TSR_TEMP_RST;
    end else if (i_conv_valid) begin
      if (o_res16) begin
        temp_r <= i_conv_data;
      end else begin
        temp_r <= {i_conv_data[15:TSR_EXT_LSB], i_above_crit, i_above_high,
                   i_below_low};
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A new event beats a clear in the same cycle, so nothing is lost
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fl_low_r <= 1'b0;
    end else if (i_below_low) begin
      fl_low_r <= 1'b1;
    end else if (st_rd || i_low_recovered) begin
      fl_low_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fl_high_r <= 1'b0;
    end else if (i_above_high) begin
      fl_high_r <= 1'b1;
    end else if (st_rd || i_high_recovered) begin
      fl_high_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fl_crit_r <= 1'b0;
    end else if (i_above_crit) begin
      fl_crit_r <= 1'b1;
    end else if (st_rd || i_crit_recovered) begin
      fl_crit_r <= 1'b0;
    end
  end

  // Ready bit is active low; a fresh result wins over a restoring access
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdy_n_r <= 1'b1;
    end else if (i_conv_valid) begin
      rdy_n_r <= 1'b0;
    end else if (temp_rd) begin
      rdy_n_r <= 1'b1;
    end else if (cfg_wr && ((wr_mode == TSR_MODE_ONE) || (wr_mode == TSR_MODE_SPS))) begin
      rdy_n_r <= 1'b1;
    end
  end

  // Read-only byte; writes to this address are ignored
  assign status_byte = {rdy_n_r, fl_crit_r, fl_high_r, fl_low_r, TSR_ST_UNUSED};
  assign o_status    = status_byte;
  assign o_ptr       = ptr_r;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped and out-of-scope addresses read as zero
  always_comb begin
    case (ptr_r)
      TSR_ADR_TEMP_HI: rd_mux = temp_r[15:8];
      TSR_ADR_TEMP_LO: rd_mux = temp_r[7:0];
      TSR_ADR_STATUS:  rd_mux = status_byte;
      TSR_ADR_CONFIG:  rd_mux = cfg_r;
      TSR_ADR_ID:      rd_mux = P_ID_CODE;
      default:         rd_mux = TSR_UNMAPPED;
    endcase
  end

  // Read byte one cycle after each read, answer pulse one cycle after each request
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_r <= 8'h00;
      ack_r   <= 1'b0;
    end else begin
      ack_r <= xf.req;
      if (rd_req) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign xf.rdata = rdata_r;
  assign xf.ack   = ack_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_PTR_RESET: assert property ($rose(i_rstn) |-> ptr_r == TSR_PTR_RST)
    else $error("pointer not zero after reset");
  AST_AUTO_INC: assert property (rd_req && ptr_r == TSR_ADR_TEMP_HI && !ptr_wr
    |=> ptr_r == TSR_ADR_TEMP_LO)
    else $error("pointer did not advance after high byte");
  AST_HI_DATA: assert property (rd_req && ptr_r == TSR_ADR_TEMP_HI && !i_conv_valid
    |=> rdata_r == temp_r[15:8] ##1 ack_r == 1'b0)
    else $error("high byte read returned wrong data");
  AST_FLAG13: assert property (i_conv_valid && !o_res16
    |=> temp_r[2:0] == {$past(i_above_crit), $past(i_above_high), $past(i_below_low)})
    else $error("alarm bits wrong in 13-bit mode");
  AST_EXT16: assert property (i_conv_valid && o_res16 |=> temp_r == $past(i_conv_data))
    else $error("result wrong in 16-bit mode");
  AST_ST_ZERO: assert property (o_status[3:0] == TSR_ST_UNUSED)
    else $error("status low bits not zero");
  AST_LOW_SET: assert property (i_below_low |=> fl_low_r)
    else $error("low flag not set");
  AST_HIGH_CLR: assert property (fl_high_r && i_high_recovered && !i_above_high
    |=> !fl_high_r)
    else $error("high flag did not clear on recovery");
  AST_CRIT_READ: assert property (st_rd && !i_above_crit
    |=> !fl_crit_r && rdata_r[TSR_ST_CRIT] == $past(fl_crit_r))
    else $error("critical flag read or clear wrong");
  AST_RDY_CYCLE: assert property (i_conv_valid |=> !rdy_n_r ##0 o_status[TSR_ST_RDY] == 1'b0)
    else $error("ready bit did not go low on result");
  AST_MODE_RDY: assert property (cfg_wr && !i_conv_valid && wr_mode == TSR_MODE_SPS
    |=> rdy_n_r && o_mode == TSR_MODE_SPS)
    else $error("mode write did not restore ready");
  AST_STAT_RO: assert property (reg_wr && ptr_r == TSR_ADR_STATUS |=> $stable(cfg_r))
    else $error("status write disturbed configuration");

  // ----------------------------------------------------------------
  // Access path checks
  // ----------------------------------------------------------------
  // Pointer and transaction phase follow the byte operations
  AST_PTR_LOAD: assert property (ptr_wr
    |=> ptr_r == $past(xf.wdata))
    else $error("pointer byte not loaded");
  AST_PH_START: assert property (xf.req && xf.op == TSR_OP_START
    |=> phase_r == TSR_PH_POINTER)
    else $error("start did not expect a pointer byte");
  AST_PH_STOP: assert property (xf.req && xf.op == TSR_OP_STOP
    |=> phase_r == TSR_PH_IDLE)
    else $error("stop did not end the transaction");
  AST_PTR_HOLD: assert property (reg_wr
    |=> $stable(ptr_r))
    else $error("pointer moved on a register write");
  AST_LO_STAY: assert property (rd_req && ptr_r == TSR_ADR_TEMP_LO
    |=> ptr_r == TSR_ADR_TEMP_LO)
    else $error("pointer left the low byte");

  // Every operation is answered, and reads carry the addressed byte
  AST_ACK: assert property (xf.req
    |=> ack_r)
    else $error("operation not answered");
  AST_LO_DATA: assert property (rd_req && ptr_r == TSR_ADR_TEMP_LO && !i_conv_valid
    |=> rdata_r == temp_r[7:0])
    else $error("low byte read returned wrong data");
  AST_ST_DATA: assert property (st_rd
    |=> rdata_r == $past(status_byte))
    else $error("status read did not return old flags");
  AST_CFG_DATA: assert property (rd_req && ptr_r == TSR_ADR_CONFIG
    |=> rdata_r == cfg_r)
    else $error("configuration read wrong");
  AST_ID: assert property (rd_req && ptr_r == TSR_ADR_ID
    |=> rdata_r == P_ID_CODE)
    else $error("identification read wrong");
  AST_UNMAPPED: assert property (rd_req && ptr_r > TSR_ADR_ID
    |=> rdata_r == TSR_UNMAPPED)
    else $error("unmapped read not zero");

  // Conversion word, flag set and flag clear
  AST_EXT13_HI: assert property (i_conv_valid
    |=> ((temp_r ^ $past(i_conv_data)) >> TSR_EXT_LSB) == TSR_TEMP_RST)
    else $error("upper result bits not stored");
  AST_HIGH_SET: assert property (i_above_high
    |=> fl_high_r)
    else $error("high flag not set");
  AST_CRIT_SET: assert property (i_above_crit
    |=> fl_crit_r)
    else $error("critical flag not set");
  AST_LOW_CLR: assert property ((st_rd || i_low_recovered) && !i_below_low
    |=> !fl_low_r)
    else $error("low flag did not clear");
  AST_CRIT_CLR: assert property (i_crit_recovered && !i_above_crit
    |=> !fl_crit_r)
    else $error("critical flag did not clear on recovery");
  AST_HIGH_READ: assert property (st_rd && !i_above_high
    |=> !fl_high_r && rdata_r[TSR_ST_HIGH] == $past(fl_high_r))
    else $error("high flag read or clear wrong");

  // Ready bit and configuration fields
  AST_RDY_READ: assert property (temp_rd && !i_conv_valid
    |=> rdy_n_r)
    else $error("temperature read did not restore ready");
  AST_ONE_RDY: assert property (cfg_wr && !i_conv_valid && wr_mode == TSR_MODE_ONE
    |=> rdy_n_r)
    else $error("one-shot write did not restore ready");
  AST_CONT_RDY: assert property (cfg_wr && !i_conv_valid
    && wr_mode inside {TSR_MODE_CONT, TSR_MODE_SHDN}
    |=> $stable(rdy_n_r))
    else $error("ready moved on a plain mode write");
  AST_CFG_WR: assert property (cfg_wr
    |=> cfg_r == $past(xf.wdata))
    else $error("configuration byte not stored");
  AST_MODE_SEL: assert property (cfg_wr
    |=> o_mode == $past(wr_mode))
    else $error("mode field not applied");
  AST_RES_SEL: assert property (cfg_wr && xf.wdata[TSR_CFG_RES]
    |=> o_res16)
    else $error("resolution bit not applied");

endmodule : tsr_regs

/* File: tsr_pkg.sv */
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  TSR_ADR_TEMP_HI = 8'h00;
  localparam logic [7:0]  TSR_ADR_TEMP_LO = 8'h01;
  localparam logic [7:0]  TSR_ADR_STATUS  = 8'h02;
  localparam logic [7:0]  TSR_ADR_CONFIG  = 8'h03;
  localparam logic [7:0]  TSR_ADR_ID      = 8'h0B;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  TSR_PTR_RST     = 8'h00;
  localparam logic [7:0]  TSR_CFG_RST     = 8'h00;
  localparam logic [15:0] TSR_TEMP_RST    = 16'h0000;
  localparam logic [7:0]  TSR_UNMAPPED    = 8'h00;
  localparam logic [3:0]  TSR_ST_UNUSED   = 4'h0;
  localparam int          TSR_CFG_RES     = 7;
  localparam int          TSR_CFG_MODE_LO = 5;
  localparam int          TSR_ST_LOW      = 4;
  localparam int          TSR_ST_HIGH     = 5;
  localparam int          TSR_ST_CRIT     = 6;
  localparam int          TSR_ST_RDY      = 7;
  localparam int          TSR_EXT_LSB     = 3;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSR_MODE_CONT = 2'h0,
    TSR_MODE_ONE  = 2'h1,
    TSR_MODE_SPS  = 2'h2,
    TSR_MODE_SHDN = 2'h3
  } tsr_mode_t;

  typedef enum logic [1:0] {
    TSR_OP_START = 2'h0,
    TSR_OP_WRITE = 2'h1,
    TSR_OP_READ  = 2'h2,
    TSR_OP_STOP  = 2'h3
  } tsr_op_t;

  typedef enum logic [1:0] {
    TSR_PH_IDLE    = 2'h0,
    TSR_PH_POINTER = 2'h1,
    TSR_PH_DATA    = 2'h2
  } tsr_phase_t;

endpackage : tsr_pkg

/* File: tsr_xfer_if.sv */
`timescale 1ns/10ps
// Byte operations handed from the link domain to the register core
interface tsr_xfer_if;
  import tsr_pkg::*;
  logic       req;    // One-cycle pulse, core clock
  tsr_op_t    op;     // Held stable while the link is busy
  logic [7:0] wdata;  // Held stable while the link is busy
  logic [7:0] rdata;  // Read byte, registered in the core
  logic       ack;    // One-cycle pulse, core clock

  modport core (input req, input op, input wdata, output rdata, output ack);
  modport link (output req, output op, output wdata, input rdata, input ack);
endinterface : tsr_xfer_if

/* File: tsr_link_cdc.sv */
`timescale 1ns/10ps
// Toggle handshake between the link clock and the core clock
module tsr_link_cdc
  import tsr_pkg::*;
(
  input  wire logic       i_clk,       // Core clock
  input  wire logic       i_rstn,      // Core reset, active low
  input  wire logic       i_lk_clk,    // Link clock
  input  wire logic       i_lk_rstn,   // Link reset, active low
  input  wire logic       i_lk_req,    // Operation request pulse
  input  wire tsr_op_t    i_lk_op,     // Operation code
  input  wire logic [7:0] i_lk_wdata,  // Write byte
  output logic            o_lk_busy,   // Operation in flight
  output logic            o_lk_done,   // Operation finished pulse
  output logic [7:0]      o_lk_rdata,  // Read byte
  tsr_xfer_if.link        xf           // Core side
);

  logic       req_tgl_r;
  tsr_op_t    op_r;
  logic [7:0] wdata_r;
  logic       busy_r;
  logic       done_r;
  logic [7:0] lrdata_r;
  logic       ack_s1_r, ack_s2_r, ack_s3_r;
  logic       req_s1_r, req_s2_r, req_s3_r;
  logic       ack_tgl_r;
  logic       accept;
  logic       ack_edge;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Requests while busy are dropped; payload must not move mid-flight
  assign accept   = i_lk_req && !busy_r;
  assign ack_edge = ack_s2_r ^ ack_s3_r;

  // Capture the request and flip the request toggle
  always_ff @(posedge i_lk_clk) begin
    if (!i_lk_rstn) begin
      req_tgl_r <= 1'b0;
      op_r      <= TSR_OP_STOP;
      wdata_r   <= 8'h00;
    end else if (accept) begin
      req_tgl_r <= ~req_tgl_r;
      op_r      <= i_lk_op;
      wdata_r   <= i_lk_wdata;
    end
  end

  // Answer toggle synchroniser, then busy, done and read data
  always_ff @(posedge i_lk_clk) begin
    if (!i_lk_rstn) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      lrdata_r <= 8'h00;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      done_r   <= ack_edge;
      if (accept) begin
        busy_r <= 1'b1;
      end else if (ack_edge) begin
        busy_r <= 1'b0;
      end
      if (ack_edge) begin
        lrdata_r <= xf.rdata;  // Core holds it until the next request
      end
    end
  end

  assign o_lk_busy  = busy_r;
  assign o_lk_done  = done_r;
  assign o_lk_rdata = lrdata_r;

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  // Request toggle synchroniser and answer toggle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (xf.ack) begin
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  assign xf.req   = req_s2_r ^ req_s3_r;
  assign xf.op    = op_r;     // Stable by the handshake
  assign xf.wdata = wdata_r;  // Stable by the handshake

endmodule : tsr_link_cdc

/* File: tsr_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host on the link side, one byte operation at a time
// ----------------------------------------------------------------
module tsr_host_model
  import tsr_pkg::*;
(
  input  wire logic       i_lk_clk,  // Link clock
  input  wire logic       i_done,    // Operation finished pulse
  input  wire logic [7:0] i_rdata,   // Read byte
  output logic            o_req,     // Request pulse
  output tsr_op_t         o_op,      // Operation code
  output logic [7:0]      o_wdata    // Write byte
);
  // Idle values at time zero
  initial begin
    o_req   = 1'b0;
    o_op    = TSR_OP_STOP;
    o_wdata = 8'h00;
  end

  // Request pulsed for one link cycle; a hung link returns ok low
  task automatic xfer(input tsr_op_t op, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge i_lk_clk);
    o_req   = 1'b1;
    o_op    = op;
    o_wdata = wd;
    @(negedge i_lk_clk);
    o_req = 1'b0;
    for (n = 0; n < 20 && ok == 1'b0; n++) begin
      @(negedge i_lk_clk);
      if (i_done === 1'b1) begin
        ok = 1'b1;
        rd = i_rdata;
      end
    end
    // Released byte must not look like the last one
    o_wdata = ~wd;
  endtask : xfer
endmodule : tsr_host_model

/* File: tb.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Register bank bench: host byte operations and sensor events
// ----------------------------------------------------------------
module tb;
  import tsr_pkg::*;
  localparam logic [7:0] P_ID = 8'hA7;  // Value arbitrary
  logic        i_clk, i_rstn, lk_clk, lk_rstn, conv_v, lk_req, lk_done, res16, lk_busy;
  logic [15:0] conv_d;
  logic [2:0]  lvl, rec;
  tsr_op_t     lk_op;
  tsr_mode_t   mode;
  logic [7:0]  lk_wd, lk_rd, cfg, status, ptr, rd;
  int          n_fail, n_tests, cyc, n_busy;

  // Core clock, 40 ns
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Link clock, 64 ns, free running so the handshake can finish
  initial begin
    lk_clk = 1'b0;
    #7;
    forever #32 lk_clk = ~lk_clk;
  end

  tsr_regs #(.P_ID_CODE(P_ID)) DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lk_clk(lk_clk), .i_lk_rstn(lk_rstn),
    .i_lk_req(lk_req), .i_lk_op(lk_op), .i_lk_wdata(lk_wd), .o_lk_busy(lk_busy),
    .o_lk_done(lk_done), .o_lk_rdata(lk_rd), .i_conv_valid(conv_v),
    .i_conv_data(conv_d), .i_below_low(lvl[0]), .i_above_high(lvl[1]),
    .i_above_crit(lvl[2]), .i_low_recovered(rec[0]), .i_high_recovered(rec[1]),
    .i_crit_recovered(rec[2]), .o_cfg(cfg), .o_res16(res16), .o_mode(mode),
    .o_status(status), .o_ptr(ptr));

  tsr_host_model HOST (
    .i_lk_clk(lk_clk), .i_done(lk_done), .i_rdata(lk_rd),
    .o_req(lk_req), .o_op(lk_op), .o_wdata(lk_wd));

  // Busy must show during every link operation
  always @(negedge lk_clk) begin
    if (lk_busy === 1'b1) n_busy++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // A link operation that never finishes counts as a mismatch
  task automatic op(input tsr_op_t o, input logic [7:0] wd);
    logic ok;
    int   b0;
    b0 = n_busy;
    HOST.xfer(o, wd, rd, ok);
    if (ok !== 1'b1) chk("link done", 8'h01, 8'h00);
    chk("link busy", 8'h01, {7'h00, (n_busy > b0) && (lk_busy === 1'b0)});
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_WRITE, a);
    op(TSR_OP_WRITE, d);
    op(TSR_OP_STOP, 8'h00);
  endtask : wr

  task automatic rd1(input logic [7:0] a, input logic [7:0] exp, input string nm);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_WRITE, a);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_READ, 8'h00);
    chk(nm, exp, rd);
    op(TSR_OP_STOP, 8'h00);
  endtask : rd1

  // One pointer write, then both temperature bytes in one transaction
  task automatic rd2(input logic [7:0] hi, input logic [7:0] lo);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_WRITE, TSR_ADR_TEMP_HI);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_READ, 8'h00);
    chk("temp hi", hi, rd);
    op(TSR_OP_READ, 8'h00);
    chk("temp lo", lo, rd);
    op(TSR_OP_STOP, 8'h00);
  endtask : rd2

  // One-cycle sensor event; levels dropped afterwards
  task automatic core(input logic c, input logic [15:0] d,
                      input logic [2:0] f, input logic [2:0] r);
    @(negedge i_clk);
    conv_v = c;
    conv_d = d;
    lvl    = f;
    rec    = r;
    @(negedge i_clk);
    conv_v = 1'b0;
    conv_d = ~d;
    lvl    = 3'h0;
    rec    = 3'h0;
    repeat (2) @(negedge i_clk);
  endtask : core

  // ----------------------------------------------------------------
  // Hang guard, sized well above the expected run
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rstn  = 1'b0;
    lk_rstn = 1'b0;
    conv_v  = 1'b0;
    conv_d  = 16'h0000;
    lvl     = 3'h0;
    rec     = 3'h0;
    n_fail  = 0;
    n_tests = 0;
    cyc     = 0;
    repeat (10) @(negedge i_clk);
    i_rstn  = 1'b1;
    lk_rstn = 1'b1;
    repeat (2) @(negedge lk_clk);
    // Reset state, then a read with no pointer write
    chk("ptr rst", 8'h00, ptr);
    chk("status rst", 8'h80, status);
    chk("cfg rst", 8'h00, cfg);
    op(TSR_OP_START, 8'h00);
    op(TSR_OP_READ, 8'h00);
    chk("temp hi rst", 8'h00, rd);
    chk("ptr inc", 8'h01, ptr);
    op(TSR_OP_READ, 8'h00);
    chk("temp lo rst", 8'h00, rd);
    op(TSR_OP_STOP, 8'h00);
    // 13-bit result with high and critical events at the same time
    core(1'b1, 16'hC8F5, 3'b110, 3'b000);
    chk("status conv", 8'h60, status);
    rd1(TSR_ADR_STATUS, 8'h60, "status rd");
    chk("flags clr", 8'h00, status);
    rd2(8'hC8, 8'hF6);
    chk("rdy back", 8'h80, status);
    rd1(TSR_ADR_TEMP_LO, 8'hF6, "temp lo single");
    // Every mode; only one-shot and 1 SPS writes restore ready
    for (int m = 0; m < 4; m++) begin
      core(1'b1, 16'h0C80, 3'b000, 3'b000);
      wr(TSR_ADR_CONFIG, {1'b0, 2'(m), 5'h00});
      chk("mode", 8'(m), {6'h00, mode});
      chk("rdy mode wr", (m == 1 || m == 2) ? 8'h80 : 8'h00, status);
      rd1(TSR_ADR_CONFIG, {1'b0, 2'(m), 5'h00}, "cfg rd");
    end
    // 16-bit result: low bits are data, flags still reach status
    wr(TSR_ADR_CONFIG, 8'h80);
    chk("res16", 8'h01, {7'h00, res16});
    core(1'b1, 16'h1234, 3'b111, 3'b000);
    rd1(TSR_ADR_STATUS, 8'h70, "status 16");
    rd2(8'h12, 8'h34);
    chk("rdy after rd", 8'h80, status);
    // Each flag set, then cleared by recovery alone
    for (int k = 0; k < 3; k++) begin
      core(1'b0, 16'h0000, 3'(1 << k), 3'b000);
      chk("flag set", 8'h80 | 8'(16 << k), status);
      core(1'b0, 16'h0000, 3'b000, 3'(1 << k));
      chk("flag recover", 8'h80, status);
    end
    // Read-only places, identification and an unmapped address
    wr(TSR_ADR_STATUS, 8'hFF);
    chk("status ro", 8'h80, status);
    wr(TSR_ADR_TEMP_HI, 8'h55);
    rd1(TSR_ADR_TEMP_HI, 8'h12, "temp ro");
    rd1(TSR_ADR_ID, P_ID, "id");
    rd1(8'h20, TSR_UNMAPPED, "unmapped");
    rd1(TSR_ADR_CONFIG, 8'h80, "cfg keep");
    report_and_stop();
  end
endmodule : tb
